// ===== pkg/tsc_pkg.sv
// Package with shared constants and types of the triggered scope capture block.
package tsc_pkg;
	// =====================================================================
	// Sample and memory geometry
	// =====================================================================
	localparam int unsigned TSC_SAMPLE_W = 12;
	localparam int unsigned TSC_MEM_DEPTH = 65536;
	localparam int unsigned TSC_ADDR_W = 16;
	localparam int unsigned TSC_NUM_SRC = 8;
	localparam int unsigned TSC_RATE_EXP_MAX = 16;
	localparam int unsigned TSC_ACC_W = TSC_SAMPLE_W + TSC_RATE_EXP_MAX;
	localparam int unsigned TSC_EMA_FRAC = 8;
	localparam int unsigned TSC_EMA_W = TSC_SAMPLE_W + TSC_EMA_FRAC;

	// =====================================================================
	// Register byte offsets on the AHB-Lite slave
	// =====================================================================
	localparam logic [7:0] TSC_OFS_CTRL = 8'h00;
	localparam logic [7:0] TSC_OFS_CMD = 8'h04;
	localparam logic [7:0] TSC_OFS_LENGTH = 8'h08;
	localparam logic [7:0] TSC_OFS_PRETRIG = 8'h0c;
	localparam logic [7:0] TSC_OFS_HOLDOFF = 8'h10;
	localparam logic [7:0] TSC_OFS_LEVEL = 8'h14;
	localparam logic [7:0] TSC_OFS_HYST = 8'h18;
	localparam logic [7:0] TSC_OFS_AVG = 8'h1c;
	localparam logic [7:0] TSC_OFS_STATUS = 8'h20;
	localparam logic [7:0] TSC_OFS_RDADDR = 8'h24;
	localparam logic [7:0] TSC_OFS_RDDATA = 8'h28;

	// =====================================================================
	// Field positions
	// =====================================================================
	localparam int unsigned TSC_CTRL_RATE_LSB = 0;
	localparam int unsigned TSC_CTRL_DECIM_BIT = 8;
	localparam int unsigned TSC_CTRL_TRIG_EN_BIT = 9;
	localparam int unsigned TSC_CTRL_SLOPE_LSB = 10;
	localparam int unsigned TSC_CTRL_SIG_SRC_LSB = 12;
	localparam int unsigned TSC_CTRL_TRIG_SRC_LSB = 16;
	localparam int unsigned TSC_CTRL_METHOD_BIT = 20;
	localparam int unsigned TSC_CTRL_AVG_EN_BIT = 21;
	localparam int unsigned TSC_CMD_RUN_BIT = 0;
	localparam int unsigned TSC_CMD_STOP_BIT = 1;
	localparam int unsigned TSC_CMD_SINGLE_BIT = 2;
	localparam int unsigned TSC_CMD_FORCE_BIT = 3;
	localparam int unsigned TSC_CMD_AVG_CLR_BIT = 4;

	// =====================================================================
	// Reset values
	// =====================================================================
	localparam logic [31:0] TSC_CTRL_RESET = 32'h0000_0000;
	localparam logic [TSC_ADDR_W:0] TSC_LENGTH_RESET = 17'h0_0400;
	localparam logic [4:0] TSC_AVG_RESET = 5'h00;

	typedef enum logic [1:0] {
		TSC_SLOPE_NONE = 2'b00,
		TSC_SLOPE_RISE = 2'b01,
		TSC_SLOPE_FALL = 2'b10,
		TSC_SLOPE_BOTH = 2'b11
	} tsc_slope_type;

	typedef enum logic [2:0] {
		TSC_ST_IDLE = 3'b000,
		TSC_ST_PRE = 3'b001,
		TSC_ST_ARMED = 3'b010,
		TSC_ST_POST = 3'b011,
		TSC_ST_HOLD = 3'b100
	} tsc_state_type;

	// Configuration carried from the register file to the capture logic.
	typedef struct packed {
		logic [4:0] rate_exp;
		logic decimate;
		logic trig_en;
		tsc_slope_type slope;
		logic [2:0] sig_src;
		logic [2:0] trig_src;
		logic level_method;
		logic [TSC_ADDR_W:0] length;
		logic [TSC_ADDR_W-1:0] pretrig;
		logic [31:0] holdoff;
		logic signed [TSC_SAMPLE_W-1:0] level;
		logic [TSC_SAMPLE_W-1:0] hyst;
		logic [4:0] avg_shift;
		logic avg_en;
	} tsc_cfg_type;

	// One reduced sample with its valid strobe.
	typedef struct packed {
		logic valid;
		logic signed [TSC_SAMPLE_W-1:0] data;
	} tsc_smp_type;
endpackage : tsc_pkg

// ===== hdl/tsc_rate_reduce.sv
// Rate reducer that decimates or block-averages by two to the power n.
`timescale 1ns/1ps
module tsc_rate_reduce
	import tsc_pkg::*;
(
	input wire logic core_clk, // Base sample clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [4:0] rate_exp, // Exponent n of the reduction.
	input wire logic decimate, // High selects decimation, low averaging.
	input wire logic signed [TSC_SAMPLE_W-1:0] in_data, // Full-rate sample.
	output tsc_smp_type out_smp // Reduced sample and its strobe.
);
	logic [TSC_RATE_EXP_MAX-1:0] phase;
	logic signed [TSC_ACC_W-1:0] acc;
	logic [4:0] exp_sat;
	logic [TSC_RATE_EXP_MAX-1:0] last_phase;
	logic block_end;
	logic signed [TSC_ACC_W-1:0] sum;
	logic signed [TSC_ACC_W-1:0] mean;

	assign exp_sat = (rate_exp > 5'(TSC_RATE_EXP_MAX)) ? 5'(TSC_RATE_EXP_MAX) : rate_exp;
	assign last_phase = TSC_RATE_EXP_MAX'((17'h0_0001 << exp_sat) - 17'h0_0001);
	// A rate change can leave the phase above the new block end; restart the block then.
	assign block_end = (phase >= last_phase);
	assign sum = acc + TSC_ACC_W'(in_data);
	assign mean = sum >>> exp_sat;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= '0;
			acc <= '0;
			out_smp <= '0;
		end else begin
			phase <= block_end ? '0 : phase + 1'b1;
			acc <= block_end ? '0 : sum;
			out_smp.valid <= block_end;
			// Decimation keeps the last sample of each block and drops the rest.
			out_smp.data <= decimate ? in_data : mean[TSC_SAMPLE_W-1:0];
		end
	end
endmodule : tsc_rate_reduce

// ===== hdl/tsc_trigger.sv
// Trigger detector with level, hysteresis and edge selection.
`timescale 1ns/1ps
module tsc_trigger
	import tsc_pkg::*;
(
	input wire logic core_clk, // Base sample clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic signed [TSC_SAMPLE_W-1:0] trig_data, // Selected trigger signal.
	input wire logic signed [TSC_SAMPLE_W-1:0] level, // Trigger level.
	input wire logic [TSC_SAMPLE_W-1:0] hyst, // Hysteresis half band.
	input wire tsc_slope_type slope, // Edge selection.
	input wire logic method, // Low level crossing, high digital bit 0.
	output logic trig_hit // One-cycle trigger event.
);
	logic above;
	logic next_above;
	logic signed [TSC_SAMPLE_W:0] hi_th;
	logic signed [TSC_SAMPLE_W:0] lo_th;
	logic rise;
	logic fall;

	assign hi_th = (TSC_SAMPLE_W+1)'(level) + $signed({1'b0, hyst});
	assign lo_th = (TSC_SAMPLE_W+1)'(level) - $signed({1'b0, hyst});
	// Hysteresis holds the comparator until the signal leaves the band.
	assign next_above = method ? trig_data[0] :
		(above ? ((TSC_SAMPLE_W+1)'(trig_data) >= lo_th) :
		((TSC_SAMPLE_W+1)'(trig_data) > hi_th));
	assign rise = next_above && !above;
	assign fall = !next_above && above;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			above <= 1'b0;
			trig_hit <= 1'b0;
		end else begin
			above <= next_above;
			unique case (slope)
				TSC_SLOPE_NONE: trig_hit <= 1'b0;
				TSC_SLOPE_RISE: trig_hit <= rise;
				TSC_SLOPE_FALL: trig_hit <= fall;
				TSC_SLOPE_BOTH: trig_hit <= rise || fall;
			endcase
		end
	end
endmodule : tsc_trigger

// ===== hdl/tsc_capture.sv
// Top of the triggered scope capture engine with its AHB-Lite register slave.
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tsc_capture
	import tsc_pkg::*;
(
	input wire logic core_clk, // Base sample clock, 200 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [TSC_NUM_SRC*TSC_SAMPLE_W-1:0] src_data, // Eight source inputs.
	input wire logic data_loss, // Upstream sample loss indication.
	input wire logic hsel, // AHB-Lite slave select.
	input wire logic [31:0] haddr, // AHB-Lite address.
	input wire logic [1:0] htrans, // AHB-Lite transfer type.
	input wire logic hwrite, // AHB-Lite write.
	input wire logic [2:0] hsize, // AHB-Lite transfer size.
	input wire logic [31:0] hwdata, // AHB-Lite write data.
	input wire logic hready, // AHB-Lite bus ready.
	output logic [31:0] hrdata, // AHB-Lite read data.
	output logic hreadyout, // AHB-Lite slave ready.
	output logic hresp, // AHB-Lite response, always OKAY.
	output logic shot_done // One-cycle pulse when a shot completes.
);
	// =====================================================================
	// Pin synchronisers
	// =====================================================================
	logic [TSC_NUM_SRC*TSC_SAMPLE_W-1:0] src_meta;
	logic [TSC_NUM_SRC*TSC_SAMPLE_W-1:0] src_sync;
	logic loss_meta;
	logic loss_sync;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_meta <= '0;
			src_sync <= '0;
			loss_meta <= 1'b0;
			loss_sync <= 1'b0;
		end else begin
			src_meta <= src_data;
			src_sync <= src_meta;
			loss_meta <= data_loss;
			loss_sync <= loss_meta;
		end
	end

	// =====================================================================
	// Registers
	// =====================================================================
	logic [31:0] ctrl;
	logic [TSC_ADDR_W:0] length;
	logic [TSC_ADDR_W-1:0] pretrig;
	logic [31:0] holdoff;
	logic [TSC_SAMPLE_W-1:0] level;
	logic [TSC_SAMPLE_W-1:0] hyst;
	logic [4:0] avg_shift;
	logic [TSC_ADDR_W-1:0] rd_addr;
	tsc_cfg_type cfg;
	logic dp_write;
	logic dp_read;
	logic [7:0] dp_addr;
	logic addr_take;
	logic wr_ctrl;
	logic wr_cmd;
	logic wr_len;
	logic wr_pre;
	logic wr_hold;
	logic wr_level;
	logic wr_hyst;
	logic wr_avg;
	logic wr_rdaddr;
	logic cmd_run;
	logic cmd_stop;
	logic cmd_single;
	logic cmd_force;
	logic cmd_avg_clr;
	logic [31:0] rd_mux;
	logic [31:0] status_word;

	assign addr_take = hsel && hready && htrans[1];
	assign wr_ctrl = dp_write && (dp_addr == TSC_OFS_CTRL);
	assign wr_cmd = dp_write && (dp_addr == TSC_OFS_CMD);
	assign wr_len = dp_write && (dp_addr == TSC_OFS_LENGTH);
	assign wr_pre = dp_write && (dp_addr == TSC_OFS_PRETRIG);
	assign wr_hold = dp_write && (dp_addr == TSC_OFS_HOLDOFF);
	assign wr_level = dp_write && (dp_addr == TSC_OFS_LEVEL);
	assign wr_hyst = dp_write && (dp_addr == TSC_OFS_HYST);
	assign wr_avg = dp_write && (dp_addr == TSC_OFS_AVG);
	assign wr_rdaddr = dp_write && (dp_addr == TSC_OFS_RDADDR);
	assign cmd_run = wr_cmd && hwdata[TSC_CMD_RUN_BIT];
	assign cmd_stop = wr_cmd && hwdata[TSC_CMD_STOP_BIT];
	assign cmd_single = wr_cmd && hwdata[TSC_CMD_SINGLE_BIT];
	assign cmd_force = wr_cmd && hwdata[TSC_CMD_FORCE_BIT];
	assign cmd_avg_clr = wr_cmd && hwdata[TSC_CMD_AVG_CLR_BIT];

	assign cfg.rate_exp = ctrl[TSC_CTRL_RATE_LSB +: 5];
	assign cfg.decimate = ctrl[TSC_CTRL_DECIM_BIT];
	assign cfg.trig_en = ctrl[TSC_CTRL_TRIG_EN_BIT];
	assign cfg.slope = tsc_slope_type'(ctrl[TSC_CTRL_SLOPE_LSB +: 2]);
	assign cfg.sig_src = ctrl[TSC_CTRL_SIG_SRC_LSB +: 3];
	assign cfg.trig_src = ctrl[TSC_CTRL_TRIG_SRC_LSB +: 3];
	assign cfg.level_method = ctrl[TSC_CTRL_METHOD_BIT];
	assign cfg.avg_en = ctrl[TSC_CTRL_AVG_EN_BIT];
	assign cfg.length = length;
	assign cfg.pretrig = pretrig;
	assign cfg.holdoff = holdoff;
	assign cfg.level = level;
	assign cfg.hyst = hyst;
	assign cfg.avg_shift = avg_shift;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_addr <= '0;
		end else if (hready) begin
			dp_write <= addr_take && hwrite;
			dp_read <= addr_take && !hwrite;
			dp_addr <= {haddr[7:2], 2'b00};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= TSC_CTRL_RESET;
			length <= TSC_LENGTH_RESET;
			pretrig <= '0;
			holdoff <= '0;
			level <= '0;
			hyst <= '0;
			avg_shift <= TSC_AVG_RESET;
			rd_addr <= '0;
		end else begin
			if (wr_ctrl) ctrl <= hwdata;
			// Shot length is clamped to the memory size.
			if (wr_len) length <= (hwdata > 32'(TSC_MEM_DEPTH)) ?
				17'(TSC_MEM_DEPTH) : hwdata[TSC_ADDR_W:0];
			if (wr_pre) pretrig <= hwdata[TSC_ADDR_W-1:0];
			if (wr_hold) holdoff <= hwdata;
			if (wr_level) level <= hwdata[TSC_SAMPLE_W-1:0];
			if (wr_hyst) hyst <= hwdata[TSC_SAMPLE_W-1:0];
			if (wr_avg) avg_shift <= hwdata[4:0];
			if (wr_rdaddr) rd_addr <= hwdata[TSC_ADDR_W-1:0];
		end
	end

	// =====================================================================
	// Source selection, rate reduction and trigger
	// =====================================================================
	logic signed [TSC_SAMPLE_W-1:0] sig_sel;
	logic signed [TSC_SAMPLE_W-1:0] trig_sel;
	tsc_smp_type red;
	logic trig_hit;

	assign sig_sel = src_sync[cfg.sig_src*TSC_SAMPLE_W +: TSC_SAMPLE_W];
	assign trig_sel = src_sync[cfg.trig_src*TSC_SAMPLE_W +: TSC_SAMPLE_W];

	tsc_rate_reduce tsc_rate_reduce_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.rate_exp(cfg.rate_exp),
		.decimate(cfg.decimate),
		.in_data(sig_sel),
		.out_smp(red)
	);

	tsc_trigger tsc_trigger_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.trig_data(trig_sel),
		.level(cfg.level),
		.hyst(cfg.hyst),
		.slope(cfg.slope),
		.method(cfg.level_method),
		.trig_hit(trig_hit)
	);

	// =====================================================================
	// Shot sequencer
	// =====================================================================
	tsc_state_type state;
	tsc_state_type next_state;
	logic running;
	logic single;
	logic force_pend;
	logic [TSC_ADDR_W-1:0] wr_ptr;
	logic [TSC_ADDR_W-1:0] start_ptr;
	logic [TSC_ADDR_W:0] cnt;
	logic [31:0] hold_cnt;
	logic shot_lost;
	logic shot_valid;
	logic fire;
	logic shot_end;
	logic [TSC_ADDR_W:0] post_len;
	logic [TSC_ADDR_W:0] sweep;
	logic sweep_on;

	// Force bypasses the trigger; a disabled trigger fires at once.
	assign fire = force_pend || trig_hit || !cfg.trig_en;
	assign post_len = cfg.length - {1'b0, cfg.pretrig};
	// The post-trigger phase lasts length minus pretrig samples at the reduced rate.
	assign shot_end = red.valid && (cnt + 1'b1 >= post_len);
	assign status_word = {26'h0, shot_valid, shot_lost, running, state};
	assign sweep_on = (state == TSC_ST_HOLD) && (sweep < cfg.length);

	always_comb begin
		next_state = state;
		unique case (state)
			TSC_ST_IDLE: if (running || single) next_state = TSC_ST_PRE;
			TSC_ST_PRE: if (red.valid && cnt + 1'b1 >= {1'b0, cfg.pretrig})
				next_state = TSC_ST_ARMED;
			TSC_ST_ARMED: if (fire) next_state = TSC_ST_POST;
			TSC_ST_POST: if (shot_end) next_state = TSC_ST_HOLD;
			TSC_ST_HOLD: if (hold_cnt >= cfg.holdoff && !sweep_on)
				next_state = (running && !single) ? TSC_ST_PRE : TSC_ST_IDLE;
			default: next_state = TSC_ST_IDLE;
		endcase
		if (cmd_stop) next_state = TSC_ST_IDLE;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= TSC_ST_IDLE;
			running <= 1'b0;
			single <= 1'b0;
			force_pend <= 1'b0;
			wr_ptr <= '0;
			start_ptr <= '0;
			cnt <= '0;
			hold_cnt <= '0;
			sweep <= '0;
			shot_lost <= 1'b0;
			shot_valid <= 1'b0;
			shot_done <= 1'b0;
		end else begin
			state <= next_state;
			running <= (running || cmd_run) && !cmd_stop && !cmd_single;
			single <= cmd_single || (single && !(state == TSC_ST_HOLD &&
				next_state != TSC_ST_HOLD)) && !cmd_stop;
			force_pend <= cmd_force || (force_pend && state != TSC_ST_ARMED);
			shot_done <= sweep_on && (sweep + 1'b1 == cfg.length);
			sweep <= (state == TSC_ST_HOLD) ? sweep + (TSC_ADDR_W+1)'(sweep_on) : '0;
			if (red.valid && (state == TSC_ST_PRE || state == TSC_ST_ARMED ||
				state == TSC_ST_POST)) wr_ptr <= wr_ptr + 1'b1;
			if (state != next_state) cnt <= '0;
			else if (red.valid) cnt <= cnt + 1'b1;
			if (state == TSC_ST_ARMED && fire)
				start_ptr <= wr_ptr - cfg.pretrig;
			hold_cnt <= (state == TSC_ST_HOLD) ? hold_cnt + 1'b1 : '0;
			if (loss_sync && state != TSC_ST_IDLE) shot_lost <= 1'b1;
			else if (state != TSC_ST_PRE && next_state == TSC_ST_PRE) shot_lost <= 1'b0;
			if (state == TSC_ST_POST && shot_end) shot_valid <= !shot_lost && !loss_sync;
		end
	end

	// =====================================================================
	// Sample memory and shot averaging
	// =====================================================================
	logic signed [TSC_EMA_W-1:0] mem [TSC_MEM_DEPTH];
	logic signed [TSC_SAMPLE_W-1:0] ring [TSC_MEM_DEPTH];
	logic avg_fresh;
	logic [TSC_ADDR_W-1:0] rd_idx;
	logic signed [TSC_EMA_W-1:0] old_val;
	logic signed [TSC_EMA_W-1:0] new_val;
	logic signed [TSC_EMA_W-1:0] ema_val;
	logic mem_we;

	assign old_val = mem[sweep[TSC_ADDR_W-1:0]];
	assign new_val = {ring[rd_idx], {TSC_EMA_FRAC{1'b0}}};
	// Filter weight is 2^-k, so about 2^k shots settle to 63 percent.
	assign ema_val = old_val + ((new_val - old_val) >>> cfg.avg_shift);
	// The ring takes reduced samples; the hold sweep folds valid shots into mem in shot order.
	assign mem_we = red.valid && state != TSC_ST_IDLE && state != TSC_ST_HOLD;
	assign rd_idx = start_ptr + sweep[TSC_ADDR_W-1:0];

	always_ff @(posedge core_clk) begin
		if (mem_we) ring[wr_ptr] <= red.data;
		if (sweep_on && shot_valid) mem[sweep[TSC_ADDR_W-1:0]] <= (cfg.avg_en && !avg_fresh) ?
			ema_val : new_val;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avg_fresh <= 1'b1;
		end else if (cmd_avg_clr) begin
			avg_fresh <= 1'b1;
		end else if (shot_done && shot_valid) begin
			avg_fresh <= 1'b0;
		end
	end

	// =====================================================================
	// Read data
	// =====================================================================
	assign rd_mux = (dp_addr == TSC_OFS_CTRL) ? ctrl :
		(dp_addr == TSC_OFS_LENGTH) ? 32'(length) :
		(dp_addr == TSC_OFS_PRETRIG) ? 32'(pretrig) :
		(dp_addr == TSC_OFS_HOLDOFF) ? holdoff :
		(dp_addr == TSC_OFS_LEVEL) ? 32'(level) :
		(dp_addr == TSC_OFS_HYST) ? 32'(hyst) :
		(dp_addr == TSC_OFS_AVG) ? 32'(avg_shift) :
		(dp_addr == TSC_OFS_STATUS) ? status_word :
		(dp_addr == TSC_OFS_RDADDR) ? 32'(rd_addr) :
		(dp_addr == TSC_OFS_RDDATA) ?
		32'(signed'(mem[rd_addr][TSC_EMA_W-1:TSC_EMA_FRAC])) : 32'h0000_0000;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata <= (addr_take && !hwrite) ? 32'h0000_0000 : hrdata;
			if (dp_read && !hreadyout) hrdata <= rd_mux;
			hreadyout <= !(addr_take && !hwrite);
			hresp <= 1'b0;
		end
	end
endmodule : tsc_capture

// ===== verif/tsc_capture_chk.sv
// Checker of bus timing and shot pacing at the capture top.
`timescale 1ns/1ps
module tsc_capture_chk
	import tsc_pkg::*;
(
	input wire logic core_clk, // Clock.
	input wire logic rst_n, // Reset.
	input wire logic [TSC_NUM_SRC*TSC_SAMPLE_W-1:0] src_data, // Sources.
	input wire logic data_loss, // Loss.
	input wire logic hsel, // Select.
	input wire logic [31:0] haddr, // Address.
	input wire logic [1:0] htrans, // Type.
	input wire logic hwrite, // Write.
	input wire logic [2:0] hsize, // Size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Ready.
	input wire logic [31:0] hrdata, // Read data.
	input wire logic hreadyout, // Slave ready.
	input wire logic hresp, // Response.
	input wire logic shot_done // Shot end.
);
	// ====
	// Snoop of length, pretrigger and rate, and a count since the last shot
	// ====
	wire logic take = hsel && hready && htrans[1];
	wire logic rd_take = take && !hwrite;
	logic wr_ph;
	logic [7:0] wr_ofs;
	logic [16:0] len;
	logic [16:0] pre;
	logic [4:0] rexp;
	logic [31:0] gap;
	wire logic [31:0] need = (len > pre) ? ({15'h0000, len - pre} << rexp) : 32'h0000_0000;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ph <= 1'b0;
			wr_ofs <= 8'h00;
			len <= TSC_LENGTH_RESET;
			pre <= 17'h0_0000;
			rexp <= 5'h00;
		end else if (hready) begin
			wr_ph <= take && hwrite;
			wr_ofs <= haddr[7:0];
			if (wr_ph && wr_ofs == TSC_OFS_LENGTH) len <= hwdata[16:0];
			if (wr_ph && wr_ofs == TSC_OFS_PRETRIG) pre <= {1'b0, hwdata[15:0]};
			if (wr_ph && wr_ofs == TSC_OFS_CTRL) rexp <= hwdata[4:0];
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) gap <= 32'h0000_0000;
		else if (shot_done) gap <= 32'h0000_0001;
		else if (gap != 32'hffff_ffff) gap <= gap + 32'h0000_0001;
	end
	// ====
	// Assertions
	// ====
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence rd_addr; rd_take; endsequence
	sequence rd_wait; !hreadyout ##1 hreadyout; endsequence
	a_read_wait: assert property (rd_addr |=> rd_wait)
		else $error("read wait state wrong");
	a_write_fast: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
		else $error("wait state without read");
	a_ready_short: assert property (!hreadyout |=> hreadyout)
		else $error("wait state too long");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout) || $past(rd_take))
		else $error("read data moved without read");
	a_done_pulse: assert property (shot_done |=> !shot_done)
		else $error("shot end not a pulse");
	a_shot_span: assert property (shot_done |-> gap >= need)
		else $error("shot shorter than points times period");
endmodule : tsc_capture_chk

bind tsc_capture tsc_capture_chk tsc_capture_chk_inst (.core_clk(core_clk), .rst_n(rst_n),
	.src_data(src_data), .data_loss(data_loss), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .shot_done(shot_done));

// ===== verif/tsc_src_model.sv
// Model of the instrument inputs feeding the capture engine.
`timescale 1ns/1ps
module tsc_src_model
	import tsc_pkg::*;
(
	input wire logic core_clk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic loss_req, // Bench asks for sample loss.
	output logic [TSC_NUM_SRC*TSC_SAMPLE_W-1:0] src_data, // Sources.
	output logic data_loss // Loss flag.
);
	logic [5:0] tick;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) tick <= 6'h00;
		else tick <= tick + 6'h01;
	end
	// Source 0 toggles every cycle, 1 to 6 hold k times 0x111, 7 is a slow square.
	always_comb begin
		src_data[11:0] = tick[0] ? 12'h300 : 12'h100;
		for (int k = 1; k < 7; k++) src_data[12*k +: 12] = 12'(k * 12'h111);
		src_data[95:84] = tick[5] ? 12'h400 : 12'h000;
	end
	assign data_loss = loss_req;
endmodule : tsc_src_model

// ===== verif/triggered_scope_capture_test.sv
// Self-checking bench of the triggered scope capture engine.
`timescale 1ns/1ps
module triggered_scope_capture_test
	import tsc_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic loss_req = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic shot_done;
	logic data_loss;
	logic [TSC_NUM_SRC*TSC_SAMPLE_W-1:0] src_data;
	int err_total = 0;
	int comparisons = 0;
	logic [31:0] q;
	logic [31:0] s0;
	logic hit;
	int n;
	tsc_capture tsc_capture_inst (.core_clk(core_clk), .rst_n(rst_n), .src_data(src_data),
		.data_loss(data_loss), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .shot_done(shot_done));
	tsc_src_model tsc_src_model_inst (.core_clk(core_clk), .rst_n(rst_n), .loss_req(loss_req),
		.src_data(src_data), .data_loss(data_loss));
	// ====
	// Helpers
	// ====
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	// One single word transfer; entered just after a rising edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		q = hrdata;
	endtask : bus
	task automatic wait_done(input int lim);
		hit = 1'b0;
		n = 0;
		while (!hit && n < lim) begin
			@(posedge core_clk);
			n++;
			hit = (shot_done === 1'b1);
		end
	endtask : wait_done
	function automatic logic [31:0] ctrl(input logic [31:0] e, t, s, g, r, v);
		return e | (t << TSC_CTRL_TRIG_EN_BIT) | (s << TSC_CTRL_SLOPE_LSB)
			| (g << TSC_CTRL_SIG_SRC_LSB) | (r << TSC_CTRL_TRIG_SRC_LSB) | (v << TSC_CTRL_AVG_EN_BIT);
	endfunction : ctrl
	task automatic shot(input logic [31:0] c, input logic [31:0] len, input logic [31:0] pre);
		bus(1'b1, TSC_OFS_CTRL, c);
		bus(1'b1, TSC_OFS_LENGTH, len);
		bus(1'b1, TSC_OFS_PRETRIG, pre);
		bus(1'b1, TSC_OFS_CMD, 32'h1 << TSC_CMD_SINGLE_BIT);
		wait_done(900);
	endtask : shot
	task automatic sample(input int i);
		bus(1'b1, TSC_OFS_RDADDR, 32'(i));
		bus(1'b0, TSC_OFS_RDDATA, 32'h0);
	endtask : sample
	// ====
	// Scenarios
	// ====
	task automatic t_regs();
		bus(1'b0, TSC_OFS_CTRL, 32'h0);
		chk(q, TSC_CTRL_RESET, "control reset");
		bus(1'b0, TSC_OFS_LENGTH, 32'h0);
		chk(q, 32'(TSC_LENGTH_RESET), "length reset");
		bus(1'b1, 8'h3c, 32'hffff_ffff);
		bus(1'b0, 8'h3c, 32'h0);
		chk(q, 32'h0, "unmapped read");
		$display("test regs done");
	endtask : t_regs
	task automatic t_rate();
		for (int e = 1; e < 4; e++) begin
			shot(ctrl(e, 0, 0, 0, 0, 0), 8, 0);
			chk(32'(n >= (8 << e)), 32'h1, "shot too short");
			for (int i = 0; i < 8; i++) begin
				sample(i);
				chk({20'h0, q[11:0]}, 32'h200, "block average");
			end
		end
		wait_done(150);
		chk(32'(hit), 32'h0, "single repeated");
		shot(ctrl(1, 0, 0, 0, 0, 0) | (32'h1 << TSC_CTRL_DECIM_BIT), 16, 0);
		sample(0);
		s0 = q;
		chk(32'(s0[11:0] == 12'h100 || s0[11:0] == 12'h300), 32'h1, "decimated value");
		for (int i = 1; i < 16; i++) begin
			sample(i);
			chk(q, s0, "decimation phase");
		end
		$display("test rate done");
	endtask : t_rate
	task automatic t_src();
		for (int k = 1; k < 7; k++) begin
			shot(ctrl(0, 0, 0, k, 0, 0), 4, 0);
			sample(2);
			chk({20'h0, q[11:0]}, 32'(12'(k * 12'h111)), "source select");
		end
		$display("test source done");
	endtask : t_src
	task automatic t_trig();
		bus(1'b1, TSC_OFS_LEVEL, 32'h200);
		bus(1'b1, TSC_OFS_HYST, 32'h10);
		bus(1'b1, TSC_OFS_HOLDOFF, 32'h0);
		shot(ctrl(0, 1, 1, 7, 1, 0), 24, 8);
		chk(32'(hit), 32'h0, "fired on flat source");
		bus(1'b1, TSC_OFS_CMD, 32'h1 << TSC_CMD_FORCE_BIT);
		wait_done(100);
		chk(32'(hit), 32'h1, "force ignored");
		for (int s = 1; s < 4; s++) begin
			shot(ctrl(0, 1, s, 7, 7, 0), 24, 8);
			sample(0);
			s0 = q;
			sample(23);
			chk(32'(hit && s0[11:0] != q[11:0]), 32'h1, "edge not in shot");
			if (s == 1) chk({20'h0, q[11:0]}, 32'h400, "rising edge");
			if (s == 2) chk({20'h0, q[11:0]}, 32'h0, "falling edge");
		end
		$display("test trigger done");
	endtask : t_trig
	task automatic t_run();
		shot(ctrl(0, 0, 0, 1, 0, 0), 16, 0);
		bus(1'b1, TSC_OFS_CMD, 32'h1 << TSC_CMD_RUN_BIT);
		for (int i = 0; i < 3; i++) begin
			wait_done(200);
			chk(32'(hit), 32'h1, "run stalled");
		end
		bus(1'b1, TSC_OFS_CMD, 32'h1 << TSC_CMD_STOP_BIT);
		wait_done(40);
		wait_done(200);
		chk(32'(hit), 32'h0, "shots after stop");
		$display("test run done");
	endtask : t_run
	task automatic t_avg();
		bus(1'b1, TSC_OFS_AVG, 32'h1);
		bus(1'b1, TSC_OFS_CMD, 32'h1 << TSC_CMD_AVG_CLR_BIT);
		shot(ctrl(0, 0, 0, 1, 0, 1), 8, 0);
		loss_req <= 1'b1;
		shot(ctrl(0, 0, 0, 6, 0, 1), 8, 0);
		loss_req <= 1'b0;
		bus(1'b0, TSC_OFS_STATUS, 32'h0);
		chk({31'h0, q[4]}, 32'h1, "loss not flagged");
		shot(ctrl(0, 0, 0, 3, 0, 1), 8, 0);
		sample(5);
		chk({20'h0, q[11:0]}, 32'h222, "moving average");
		bus(1'b1, TSC_OFS_CMD, 32'h1 << TSC_CMD_AVG_CLR_BIT);
		shot(ctrl(0, 0, 0, 3, 0, 1), 8, 0);
		sample(5);
		chk({20'h0, q[11:0]}, 32'h333, "average not cleared");
		$display("test average done");
	endtask : t_avg
	// ====
	// Clock, sequence and watchdog
	// ====
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_rate();
		t_src();
		t_trig();
		t_run();
		t_avg();
		close_out();
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		err_total++;
		$display("FAIL t=%0t watchdog expired", $time);
		close_out();
	end
endmodule : triggered_scope_capture_test
